/* File: verilog/psc_map.vh */
// register offsets, field positions and reset values of the special control
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
`define PSC_OFF_SPECIAL   8'h00
`define PSC_OFF_STRAP     8'h04
`define PSC_OFF_MODE      8'h08
`define PSC_OFF_SOFTRST   8'h0C
`define PSC_BIT_XOVR_SEL  15
`define PSC_BIT_AUTO_EN   14
`define PSC_BIT_XSTATE    13
`define PSC_BIT_HB_DIS    11
`define PSC_BIT_PLL_FORCE 10
`define PSC_BIT_POL       4
`define PSC_SPECIAL_RST   16'h0000
`define PSC_MODE_MANUAL   2'h0
`define PSC_MODE_CROSS    2'h1
`define PSC_MODE_AUTO     2'h2
`define PSC_MODE_RSVD     2'h3
`endif

/* File: verilog/psc_xover_decode.v */
// crossover mode decoder from enable/state pair
`timescale 1ns/1ps
module psc_xover_decode
(
    input  wire       auto_en_i,   // auto crossover enable
    input  wire       state_i,     // crossover state
    output reg  [1:0] mode_o       // decoded mode
);
`include "psc_map.vh"
    // reserved pair reported as its own code so it is visible
    always @*
    begin
        case ({auto_en_i, state_i})
            2'h0:    mode_o = `PSC_MODE_MANUAL;
            2'h1:    mode_o = `PSC_MODE_CROSS;
            2'h2:    mode_o = `PSC_MODE_AUTO;
            default: mode_o = `PSC_MODE_RSVD;
        endcase
    end
endmodule // psc_xover_decode

/* File: verilog/psc_special_ctrl.v */
// port phy special control register bank on classic wishbone
// Behaviour
// - bit 11 set disables heartbeat test; default 0, test runs.
// - bit 10 set forces 10M rx pll onto reference; rx blocked.
// - bit 4 read-only polarity: 0 normal, 1 reversed; resets to 0.
// - bits 11 and 10 return to default on chip-level port phy reset.
// - phy soft reset bit in basic control also resets those bits.
// - crossover mode decoded from enable bit 14 and state bit 13.
// - bit 15 set lets bits 14:13 override straps; clear uses straps.
`timescale 1ns/1ps
module psc_special_ctrl
(
    input  wire        clk_i,             // 10 MHz clock
    input  wire        rst_i,             // sync reset, active high
    input  wire        wb_cyc_i,          // bus cycle
    input  wire        wb_stb_i,          // strobe
    input  wire        wb_we_i,           // write enable
    input  wire [7:0]  wb_adr_i,          // byte address
    input  wire [3:0]  wb_sel_i,          // byte lanes
    input  wire [31:0] wb_dat_i,          // write data
    output reg  [31:0] wb_dat_o,          // read data
    output reg         wb_ack_o,          // acknowledge
    input  wire        chip_phy_soft_reset_bit_i,    // port reset from chip control
    input  wire        phy_soft_reset_bit_i, // basic control reset bit
    input  wire        pol_reversed_i,    // detected rx polarity
    input  wire        strap_manual_i,    // manual crossover strap
    input  wire        strap_auto_i,      // auto crossover strap
    output reg         heartbeat_test_disable_o, // heartbeat test off
    output reg         rx_pll_ref_lock_force_o,  // pll held on ref
    output reg  [1:0]  xover_mode_o       // effective crossover mode
);
`include "psc_map.vh"

    // address map, byte offsets on the low eight address bits:
    //   0x00 special control, bits 15:13, 11, 10 writable, bit 4 status
    //   0x04 strap levels {auto, manual}, read only
    //   0x08 crossover mode in force, read only
    //   0x0C bit 0 written as 1 fires a soft reset of the fields
    // only a full match decodes; aliases would hide software bugs

    reg         xsel_q;
    reg         auto_en_q;
    reg         xstate_q;
    reg         hb_dis_q;
    reg         pll_force_q;
    reg         pol_q;
    reg         soft_rst_q;   // latched pulse of software reset
    wire [1:0]  reg_mode;
    wire [1:0]  strap_mode;
    wire        acc;
    wire        wr_lo;
    wire        wr_hi;
    wire [15:0] special_rd;
    reg         xsel_d;
    reg         auto_en_d;
    reg         xstate_d;
    reg         hb_dis_d;
    reg         pll_force_d;
    reg         soft_rst_d;
    wire        wr_special;
    wire        wr_softrst;
    wire        fld_clr;      // any soft-reset class clear

    // exact byte-address match; shared by every write decoder so that
    // no offset can alias another through a partial compare
    function addr_is;
        input [7:0] adr;
        input [7:0] off;
        begin
            addr_is = (adr == off);
        end
    endfunction

    // one decoder instance per crossover source
    // the strap pair uses the same table: auto strap acts as enable
    psc_xover_decode u_reg_dec
    (
        .auto_en_i (auto_en_q),
        .state_i   (xstate_q),
        .mode_o    (reg_mode)
    );
    psc_xover_decode u_strap_dec
    (
        .auto_en_i (strap_auto_i),
        .state_i   (strap_manual_i),
        .mode_o    (strap_mode)
    );

    // a request is taken once; the registered ack masks the held
    // strobe, so a cycle held over two edges never writes twice
    assign acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_lo = acc & wb_we_i & wb_sel_i[0];
    assign wr_hi = acc & wb_we_i & wb_sel_i[1];

    // write strobes of the two writable words
    assign wr_special = wr_hi & addr_is(wb_adr_i, `PSC_OFF_SPECIAL);
    assign wr_softrst = wr_lo & addr_is(wb_adr_i, `PSC_OFF_SOFTRST);
    // a clear from any source of the soft-reset class
    assign fld_clr    = chip_phy_soft_reset_bit_i | phy_soft_reset_bit_i | soft_rst_q;

    // reserved positions are constant zero in the read image
    assign special_rd = {xsel_q, auto_en_q, xstate_q, 1'b0,
                         hb_dis_q, pll_force_q, 5'h00,
                         pol_q, 4'h0};

    // next field values; a clear from any of the three reset sources beats a write
    // in the same cycle, so software cannot keep a stale setting alive
    always @*
    begin
        xsel_d      = xsel_q;
        auto_en_d   = auto_en_q;
        xstate_d    = xstate_q;
        hb_dis_d    = hb_dis_q;
        pll_force_d = pll_force_q;
        if (fld_clr)
        begin
            xsel_d      = 1'b0;
            auto_en_d   = 1'b0;
            xstate_d    = 1'b0;
            hb_dis_d    = 1'b0;
            pll_force_d = 1'b0;
        end
        else if (wr_special)
        begin
            xsel_d      = wb_dat_i[`PSC_BIT_XOVR_SEL];
            auto_en_d   = wb_dat_i[`PSC_BIT_AUTO_EN];
            xstate_d    = wb_dat_i[`PSC_BIT_XSTATE];
            hb_dis_d    = wb_dat_i[`PSC_BIT_HB_DIS];
            pll_force_d = wb_dat_i[`PSC_BIT_PLL_FORCE];
        end
    end

    // software reset request is a one-cycle pulse; it clears the
    // fields one cycle after the write that fires it
    always @*
    begin
        soft_rst_d = 1'b0;
        if (wr_softrst && wb_dat_i[0])
            soft_rst_d = 1'b1;
    end

    // field registers; the device reset puts every field at its default
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            xsel_q      <= 1'b0;
            auto_en_q   <= 1'b0;
            xstate_q    <= 1'b0;
            hb_dis_q    <= 1'b0;
            pll_force_q <= 1'b0;
            soft_rst_q  <= 1'b0;
        end
        else
        begin
            xsel_q      <= xsel_d;
            auto_en_q   <= auto_en_d;
            xstate_q    <= xstate_d;
            hb_dis_q    <= hb_dis_d;
            pll_force_q <= pll_force_d;
            soft_rst_q  <= soft_rst_d;
        end
    end

    // polarity is a status sample, cleared by reset
    // the status pin is taken as synchronous, so no extra stage here
    always @(posedge clk_i)
    begin
        if (rst_i)
            pol_q <= 1'b0;
        else
            pol_q <= pol_reversed_i;
    end

    // outputs straight from flops
    // one cycle behind the fields; the phy side sees clean levels
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            heartbeat_test_disable_o <= 1'b0;
            rx_pll_ref_lock_force_o  <= 1'b0;
            xover_mode_o             <= `PSC_MODE_MANUAL;
        end
        else
        begin
            heartbeat_test_disable_o <= hb_dis_q;
            rx_pll_ref_lock_force_o  <= pll_force_q;
            xover_mode_o <= xsel_q ? reg_mode : strap_mode;
        end
    end

    // wishbone slave: one-cycle ack, unmapped reads return zero
    // writes land on the taking edge; read data stands with the ack
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= acc;
            if (acc && !wb_we_i)
            begin
                case (wb_adr_i)
                    `PSC_OFF_SPECIAL: wb_dat_o <= {16'h0000, special_rd};
                    `PSC_OFF_STRAP:   wb_dat_o <= {30'h00000000,
                                                   strap_auto_i,
                                                   strap_manual_i};
                    `PSC_OFF_MODE:    wb_dat_o <= {30'h00000000,
                                                   xover_mode_o};
                    default:          wb_dat_o <= 32'h00000000;
                endcase
            end
            else
                wb_dat_o <= 32'h00000000;
        end
    end
endmodule // psc_special_ctrl

/* File: verif/psc_special_ctrl_properties.sv */
// port checks of the special control bank
`timescale 1ns/1ps
module psc_props
(
    input wire logic        clk_i,                    // clock
    input wire logic        rst_i,                    // sync reset
    input wire logic        wb_cyc_i,                 // bus cycle
    input wire logic        wb_stb_i,                 // strobe
    input wire logic        wb_we_i,                  // write enable
    input wire logic [7:0]  wb_adr_i,                 // address
    input wire logic [3:0]  wb_sel_i,                 // lanes
    input wire logic [31:0] wb_dat_i,                 // write data
    input wire logic [31:0] wb_dat_o,                 // read data
    input wire logic        wb_ack_o,                 // acknowledge
    input wire logic        chip_phy_soft_reset_bit_i,           // chip port reset
    input wire logic        phy_soft_reset_bit_i,     // basic ctrl reset
    input wire logic        pol_reversed_i,           // polarity status
    input wire logic        strap_manual_i,           // manual strap
    input wire logic        strap_auto_i,             // auto strap
    input wire logic        heartbeat_test_disable_o, // heartbeat off
    input wire logic        rx_pll_ref_lock_force_o,  // pll on ref
    input wire logic [1:0]  xover_mode_o              // crossover mode
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // read answer of the special register
    wire rd0 = wb_ack_o && !wb_we_i && wb_adr_i == 8'h00;
    wire wr0 = wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[1];
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
    hb_write_a: assert property (wr0 |=>
        heartbeat_test_disable_o == $past(wb_dat_i[11])) else $error("hb");
    pll_write_a: assert property (wr0 |=>
        rx_pll_ref_lock_force_o == $past(wb_dat_i[10])) else $error("pll");
    pol_read_a: assert property (rd0 && $stable(pol_reversed_i) &&
        $past(pol_reversed_i, 2) == pol_reversed_i
        |-> wb_dat_o[4] == pol_reversed_i) else $error("polarity");
    chip_clear_a: assert property (chip_phy_soft_reset_bit_i |-> ##2
        !heartbeat_test_disable_o && !rx_pll_ref_lock_force_o)
        else $error("chip reset");
    soft_clear_a: assert property (phy_soft_reset_bit_i |-> ##2
        !heartbeat_test_disable_o && !rx_pll_ref_lock_force_o)
        else $error("soft reset");
    mode_decode_a: assert property (rd0 && wb_dat_o[15]
        |-> xover_mode_o == wb_dat_o[14:13]) else $error("mode");
    strap_mode_a: assert property (rd0 && !wb_dat_o[15] &&
        $stable({strap_auto_i, strap_manual_i})
        |-> xover_mode_o == {strap_auto_i, strap_manual_i})
        else $error("strap");
    mode_read_a: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == 8'h08 |-> wb_dat_o == {30'h0, $past(xover_mode_o)})
        else $error("mode readback");
    rsvd_zero_a: assert property (rd0
        |-> (wb_dat_o & 32'hFFFF13EF) == 0) else $error("reserved");
    cover property (chip_phy_soft_reset_bit_i);
    cover property (wr0);
    cover property (xover_mode_o == 2'h2);
endmodule // psc_props
bind psc_special_ctrl psc_props u_props(.*);

/* File: verif/psc_special_ctrl_test.sv */
// directed bench of the special control bank
`timescale 1ns/1ps
module psc_special_ctrl_test;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd_q;
    logic wb_ack_o, chip_phy_soft_reset_bit_i = 0, phy_soft_reset_bit_i = 0;
    logic pol_reversed_i = 0, strap_manual_i = 0, strap_auto_i = 0;
    logic heartbeat_test_disable_o, rx_pll_ref_lock_force_o;
    logic [1:0] xover_mode_o;
    int miscompares = 0, checks_done = 0, cyc_n = 0, i;
    psc_special_ctrl uut(.*);
    initial forever #50 clk_i = ~clk_i;
    task chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    // one classic cycle, held until ack is seen
    task acc(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd_q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task rc(string n, logic [7:0] a, logic [31:0] e);
        acc(0, a, 0, 4'hF);
        chk(n, e, rd_q);
    endtask
    task give_verdict;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, whole run needs about a hundred cycles
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n > 2000)
        begin
            miscompares++;
            give_verdict;
        end
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        rc("rst", 8'h00, 0);
        pol_reversed_i <= 1;
        acc(1, 8'h00, 32'hFFFFAFFF, 4'hF);
        repeat (2) @(posedge clk_i);
        chk("outs", 4'hD, {heartbeat_test_disable_o, rx_pll_ref_lock_force_o,
            xover_mode_o});
        rc("fld", 8'h00, 32'hAC10);
        acc(1, 8'h00, 0, 4'hD);
        rc("sel", 8'h00, 32'hAC10);
        $display("field test end");
        for (i = 0; i < 3; i++)
        begin
            acc(1, 8'h00, 32'h8000 | (i << 13), 4'hF);
            repeat (2) @(posedge clk_i);
            chk("mode", i, xover_mode_o);
        end
        $display("mode test end");
        // second pass uses the basic control reset input
        for (i = 0; i < 2; i++)
        begin
            acc(1, 8'h00, 32'hCC00, 4'hF);
            chip_phy_soft_reset_bit_i <= (i == 0);
            phy_soft_reset_bit_i <= (i == 1);
            @(posedge clk_i);
            {chip_phy_soft_reset_bit_i, phy_soft_reset_bit_i} <= 2'b00;
            repeat (2) @(posedge clk_i);
            chk("clr", 32'h0, {heartbeat_test_disable_o,
                rx_pll_ref_lock_force_o, xover_mode_o});
            rc("rdclr", 8'h00, 32'h10);
        end
        $display("reset test end");
        strap_auto_i <= 1;
        repeat (3) @(posedge clk_i);
        chk("strap", 2, xover_mode_o);
        rc("straps", 8'h04, 2);
        {strap_auto_i, strap_manual_i} <= 2'h1;
        repeat (3) @(posedge clk_i);
        chk("strap1", 1, xover_mode_o);
        rc("modrd", 8'h08, 1);
        acc(1, 8'h00, 32'hCC00, 4'hF);
        repeat (2) @(posedge clk_i);
        chk("ovr", 2, xover_mode_o);
        // software path to the soft reset of the fields
        acc(1, 8'h0C, 1, 4'h1);
        repeat (2) @(posedge clk_i);
        chk("swclr", 1, {heartbeat_test_disable_o,
            rx_pll_ref_lock_force_o, xover_mode_o});
        rc("swrd", 8'h00, 32'h10);
        rc("unmap", 8'h10, 0);
        $display("strap test end");
        give_verdict;
    end
endmodule // psc_special_ctrl_test
